// ==== hw/cmm_pkg.sv ====
// Shared constants and types of the processor memory master ports
package cmm_pkg;
  localparam int          DATA_W     = 32;
  localparam int          BE_W       = 4;
  localparam int          BYTE_W     = 8;
  localparam int          LANE_W     = 2;
  localparam int          BYPASS_BIT = 31;
  localparam int          MAX_OUT    = 4;
  localparam int          DC_LINES   = 16;
  localparam logic [31:0] RESET_PC   = 32'h0000_0000;
  localparam logic [31:0] FETCH_STEP = 32'h0000_0004;
  localparam logic [1:0]  SZ_BYTE    = 2'h0;
  localparam logic [1:0]  SZ_HALF    = 2'h1;
  localparam logic [1:0]  SZ_WORD    = 2'h2;
  localparam logic [3:0]  BE_BYTE    = 4'h1;
  localparam logic [3:0]  BE_HALF    = 4'h3;
  localparam logic [3:0]  BE_WORD    = 4'hf;
  localparam logic [1:0]  LANE_ZERO  = 2'h0;
  typedef enum logic {CMM_LS_IDLE, CMM_LS_BUS} cmm_ls_e;
  typedef enum logic {CMM_DB_IDLE, CMM_DB_BUSY} cmm_db_e;
endpackage : cmm_pkg

// ==== hw/cmm_lsu_if.sv ====
// Request and answer carrier between load/store control and bus engine
`timescale 1ns/10ps
`default_nettype none
interface cmm_lsu_if;
  logic        req;
  logic        write;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [3:0]  be;
  logic        done;
  logic [31:0] rdata;
  modport ctl (output req, write, addr, wdata, be, input done, rdata);
  modport eng (input req, write, addr, wdata, be, output done, rdata);
endinterface : cmm_lsu_if
`default_nettype wire

// ==== hw/cmm_dbus.sv ====
// Data master engine: one transfer at a time, wait states stall
`timescale 1ns/10ps
`default_nettype none
module cmm_dbus (
  input  wire logic        sys_clk,        // Clock
  input  wire logic        sys_rst,        // Sync reset
  cmm_lsu_if.eng           lsu,            // Control side
  output logic             dm_read,        // Read strobe
  output logic             dm_write,       // Write strobe
  output logic [31:0]      dm_address,     // Word address
  output logic [3:0]       dm_byteenable,  // Byte lanes
  output logic [31:0]      dm_writedata,   // Store data
  input  wire logic        dm_waitrequest, // Target stall
  input  wire logic [31:0] dm_readdata     // Load data
);
  cmm_pkg::cmm_db_e state_q, state_d;
  logic        rd_q, rd_d, wr_q, wr_d;
  logic [31:0] addr_q, addr_d, wd_q, wd_d;
  logic [3:0]  be_q, be_d;

  assign dm_read       = rd_q;
  assign dm_write      = wr_q;
  assign dm_address    = addr_q;
  assign dm_byteenable = be_q;
  assign dm_writedata  = wd_q;
  assign lsu.done      = (state_q == cmm_pkg::CMM_DB_BUSY) && !dm_waitrequest;
  assign lsu.rdata     = dm_readdata;

  always_comb begin
    state_d = state_q;
    rd_d    = rd_q;
    wr_d    = wr_q;
    addr_d  = addr_q;
    wd_d    = wd_q;
    be_d    = be_q;
    case (state_q)
      cmm_pkg::CMM_DB_IDLE: begin
        if (lsu.req) begin
          rd_d    = !lsu.write;
          wr_d    = lsu.write;
          addr_d  = lsu.addr;
          wd_d    = lsu.wdata;
          be_d    = lsu.write ? lsu.be : cmm_pkg::BE_WORD;
          state_d = cmm_pkg::CMM_DB_BUSY;
        end
      end
      default: begin
        // Wait states hold the transfer; nothing else is issued
        if (!dm_waitrequest) begin
          rd_d    = 1'b0;
          wr_d    = 1'b0;
          state_d = cmm_pkg::CMM_DB_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= cmm_pkg::CMM_DB_IDLE;
      rd_q    <= 1'b0;
      wr_q    <= 1'b0;
      addr_q  <= 32'h0;
      wd_q    <= 32'h0;
      be_q    <= 4'h0;
    end else begin
      state_q <= state_d;
      rd_q    <= rd_d;
      wr_q    <= wr_d;
      addr_q  <= addr_d;
      wd_q    <= wd_d;
      be_q    <= be_d;
    end
  end
endmodule : cmm_dbus
`default_nettype wire

// ==== hw/cmm_fetch.sv ====
// Pipelined read-only instruction fetch master with prefetch
`timescale 1ns/10ps
`default_nettype none
module cmm_fetch #(
  parameter logic [31:0] RESET_PC = cmm_pkg::RESET_PC,
  parameter int          MAX_OUT  = cmm_pkg::MAX_OUT
) (
  input  wire logic        sys_clk,          // Clock
  input  wire logic        sys_rst,          // Sync reset
  input  wire logic        steer,            // Redirect or predicted jump
  input  wire logic [31:0] steer_pc,         // New fetch address
  output logic             insn_valid,       // Instruction word pulse
  output logic [31:0]      insn_word,        // Instruction word
  output logic [31:0]      insn_pc,          // Its address
  output logic             im_read,          // Read strobe
  output logic [31:0]      im_address,       // Fetch address
  input  wire logic        im_waitrequest,   // Target stall
  input  wire logic [31:0] im_readdata,      // Returned word
  input  wire logic        im_readdatavalid  // Return strobe
);
  localparam int PW = $clog2(MAX_OUT);
  localparam int CW = $clog2(MAX_OUT + 1);

  logic [31:0]        pc_mem [MAX_OUT];
  logic [MAX_OUT-1:0] stale_q, stale_d;
  logic [PW-1:0]      wp_q, wp_d, rp_q, rp_d;
  logic [CW-1:0]      cnt_q, cnt_d;
  logic               read_q, read_d, hst_q, hst_d, pend_q, pend_d;
  logic [31:0]        addr_q, addr_d, ppc_q, ppc_d;
  logic               val_q, val_d;
  logic [31:0]        word_q, word_d, opc_q, opc_d;
  logic               acc, ret;

  assign acc        = read_q && !im_waitrequest;
  assign ret        = im_readdatavalid;
  assign im_read    = read_q;
  assign im_address = addr_q;
  assign insn_valid = val_q;
  assign insn_word  = word_q;
  assign insn_pc    = opc_q;

  always_comb begin
    cnt_d   = cnt_q + CW'(acc) - CW'(ret);
    stale_d = stale_q;
    if (acc) stale_d[wp_q] = hst_q | steer;
    if (steer) stale_d = '1;
    wp_d   = wp_q + PW'(acc);
    rp_d   = rp_q + PW'(ret);
    read_d = read_q;
    addr_d = addr_q;
    hst_d  = hst_q;
    pend_d = pend_q;
    ppc_d  = ppc_q;
    if (read_q && !acc) begin
      // Held request keeps its address; a redirect waits behind it
      if (steer) begin
        hst_d  = 1'b1;
        pend_d = 1'b1;
        ppc_d  = steer_pc;
      end
    end else begin
      if (steer) addr_d = steer_pc;
      else if (pend_q) addr_d = ppc_q;
      else if (acc) addr_d = addr_q + cmm_pkg::FETCH_STEP;
      read_d = cnt_d < CW'(MAX_OUT);
      hst_d  = 1'b0;
      pend_d = 1'b0;
    end
    val_d  = ret && !stale_q[rp_q] && !steer;
    word_d = ret ? im_readdata : word_q;
    opc_d  = ret ? pc_mem[rp_q] : opc_q;
  end

  always_ff @(posedge sys_clk) begin
    if (acc) pc_mem[wp_q] <= addr_q;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stale_q <= '0;
      wp_q    <= '0;
      rp_q    <= '0;
      cnt_q   <= '0;
      read_q  <= 1'b0;
      addr_q  <= RESET_PC;
      hst_q   <= 1'b0;
      pend_q  <= 1'b0;
      ppc_q   <= 32'h0;
      val_q   <= 1'b0;
      word_q  <= 32'h0;
      opc_q   <= 32'h0;
    end else begin
      stale_q <= stale_d;
      wp_q    <= wp_d;
      rp_q    <= rp_d;
      cnt_q   <= cnt_d;
      read_q  <= read_d;
      addr_q  <= addr_d;
      hst_q   <= hst_d;
      pend_q  <= pend_d;
      ppc_q   <= ppc_d;
      val_q   <= val_d;
      word_q  <= word_d;
      opc_q   <= opc_d;
    end
  end

  default clocking fcb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  fetch_hold_a: assert property (
    im_read && im_waitrequest |=> im_read && $stable(im_address))
    else $error("fetch request changed while stalled");
  out_limit_a: assert property (cnt_q <= CW'(MAX_OUT))
    else $error("too many fetches outstanding");
  fetch_align_a: assert property (
    im_read |-> im_address[1:0] == cmm_pkg::LANE_ZERO)
    else $error("fetch address not word aligned");
  seq_step_a: assert property (
    acc && !steer && !pend_q
    |=> addr_q == $past(addr_q) + cmm_pkg::FETCH_STEP)
    else $error("prefetch did not advance one word");
  pipe_cov: cover property (acc && cnt_q != '0);
endmodule : cmm_fetch
`default_nettype wire

// ==== hw/cmm_master_ports.sv ====
// Processor memory master ports: fetch, load/store, data cache
`timescale 1ns/10ps
`default_nettype none
module cmm_master_ports #(
  parameter logic [31:0] RESET_PC     = cmm_pkg::RESET_PC,
  parameter int          MAX_OUT      = cmm_pkg::MAX_OUT,
  parameter int          DC_LINES     = cmm_pkg::DC_LINES,
  parameter bit          DC_EN        = 1'b1,
  parameter bit          BIT31_BYPASS = 1'b1
) (
  input  wire logic        sys_clk,          // Clock
  input  wire logic        sys_rst,          // Sync reset
  input  wire logic        steer,            // Fetch redirect pulse
  input  wire logic [31:0] steer_pc,         // Redirect target
  output logic             insn_valid,       // Instruction pulse
  output logic [31:0]      insn_word,        // Instruction word
  output logic [31:0]      insn_pc,          // Instruction address
  output logic             im_read,          // Fetch read strobe
  output logic [31:0]      im_address,       // Fetch address
  input  wire logic        im_waitrequest,   // Fetch stall
  input  wire logic [31:0] im_readdata,      // Fetch data
  input  wire logic        im_readdatavalid, // Fetch data strobe
  input  wire logic        lsu_req,          // Load/store request
  input  wire logic        lsu_write,        // Store when high
  input  wire logic        lsu_uncached,     // Bypass data cache
  input  wire logic [1:0]  lsu_size,         // Byte, half, word
  input  wire logic        lsu_signed,       // Sign-extend load
  input  wire logic [31:0] lsu_addr,         // Byte address
  input  wire logic [31:0] lsu_wdata,        // Store data
  output logic             lsu_done,         // Access done pulse
  output logic [31:0]      lsu_rdata,        // Load result
  input  wire logic        dc_inv_line,      // Invalidate one line
  input  wire logic        dc_inv_all,       // Invalidate all lines
  input  wire logic [31:0] dc_inv_addr,      // Line to invalidate
  output logic             dm_read,          // Data read strobe
  output logic             dm_write,         // Data write strobe
  output logic [31:0]      dm_address,       // Data word address
  output logic [3:0]       dm_byteenable,    // Byte lanes
  output logic [31:0]      dm_writedata,     // Store data
  input  wire logic        dm_waitrequest,   // Data stall
  input  wire logic [31:0] dm_readdata       // Load data
);
  localparam int IW = $clog2(DC_LINES);
  localparam int TW = 32 - IW - cmm_pkg::LANE_W;

  cmm_lsu_if lsu ();

  cmm_fetch #(
    .RESET_PC (RESET_PC),
    .MAX_OUT  (MAX_OUT)
  ) u_fetch (
    .sys_clk          (sys_clk),
    .sys_rst          (sys_rst),
    .steer            (steer),
    .steer_pc         (steer_pc),
    .insn_valid       (insn_valid),
    .insn_word        (insn_word),
    .insn_pc          (insn_pc),
    .im_read          (im_read),
    .im_address       (im_address),
    .im_waitrequest   (im_waitrequest),
    .im_readdata      (im_readdata),
    .im_readdatavalid (im_readdatavalid)
  );

  cmm_dbus u_dbus (
    .sys_clk        (sys_clk),
    .sys_rst        (sys_rst),
    .lsu            (lsu.eng),
    .dm_read        (dm_read),
    .dm_write       (dm_write),
    .dm_address     (dm_address),
    .dm_byteenable  (dm_byteenable),
    .dm_writedata   (dm_writedata),
    .dm_waitrequest (dm_waitrequest),
    .dm_readdata    (dm_readdata)
  );

  // Lane select, then zero or sign extension
  function automatic logic [31:0] load_fmt(
    input logic [31:0] w,
    input logic [1:0]  lane,
    input logic [1:0]  size,
    input logic        sgn);
    logic [31:0] s;
    s = w >> {lane, 3'b000};
    if (size == cmm_pkg::SZ_BYTE)
      load_fmt = {{24{sgn & s[7]}}, s[7:0]};
    else if (size == cmm_pkg::SZ_HALF)
      load_fmt = {{16{sgn & s[15]}}, s[15:0]};
    else
      load_fmt = s;
  endfunction : load_fmt

  // Byte-wise merge of store data into a cached word
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] nw,
    input logic [3:0]  be);
    merge = old;
    for (int i = 0; i < cmm_pkg::BE_W; i++) begin
      if (be[i]) merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction : merge

  logic [31:0]         dc_data [DC_LINES];
  logic [TW-1:0]       dc_tag  [DC_LINES];
  logic [DC_LINES-1:0] dc_val_q, dc_val_d;
  cmm_pkg::cmm_ls_e    ls_q, ls_d;
  logic                done_q, done_d;
  logic [31:0]         rdat_q, rdat_d;
  logic [1:0]          lane;
  logic [3:0]          be;
  logic [31:0]         wlanes;
  logic [IW-1:0]       idx, inv_idx;
  logic [TW-1:0]       tag;
  logic                bypass, hit, accept, hit_load, go_bus;
  logic                fill, st_upd;

  assign lane    = lsu_addr[1:0];
  assign idx     = lsu_addr[IW+1:2];
  assign tag     = lsu_addr[31:IW+2];
  assign inv_idx = dc_inv_addr[IW+1:2];

  always_comb begin
    // Little-endian lanes: low address is low byte
    if (lsu_size == cmm_pkg::SZ_BYTE) begin
      be     = cmm_pkg::BE_BYTE << lane;
      wlanes = {4{lsu_wdata[7:0]}};
    end else if (lsu_size == cmm_pkg::SZ_HALF) begin
      be     = cmm_pkg::BE_HALF << {lane[1], 1'b0};
      wlanes = {2{lsu_wdata[15:0]}};
    end else begin
      be     = cmm_pkg::BE_WORD;
      wlanes = lsu_wdata;
    end
  end

  // Uncached, bit-31 space, or no cache: always a bus transfer
  assign bypass   = lsu_uncached || !DC_EN ||
                    (BIT31_BYPASS && lsu_addr[cmm_pkg::BYPASS_BIT]);
  assign hit      = dc_val_q[idx] && (dc_tag[idx] == tag);
  assign accept   = lsu_req && !done_q && (ls_q == cmm_pkg::CMM_LS_IDLE);
  assign hit_load = accept && !lsu_write && !bypass && hit;
  assign go_bus   = accept && !hit_load;

  assign lsu.req   = go_bus;
  assign lsu.write = lsu_write;
  assign lsu.addr  = {lsu_addr[31:2], cmm_pkg::LANE_ZERO};
  assign lsu.wdata = wlanes;
  assign lsu.be    = be;

  // Loads fill on miss; stores write through and update on hit
  assign fill   = lsu.done && !lsu_write && !bypass;
  assign st_upd = lsu.done && lsu_write && !bypass && hit;

  always_comb begin
    ls_d   = ls_q;
    done_d = hit_load || lsu.done;
    rdat_d = rdat_q;
    case (ls_q)
      cmm_pkg::CMM_LS_IDLE: begin
        if (go_bus) ls_d = cmm_pkg::CMM_LS_BUS;
        if (hit_load)
          rdat_d = load_fmt(dc_data[idx], lane, lsu_size, lsu_signed);
      end
      default: begin
        if (lsu.done) begin
          ls_d = cmm_pkg::CMM_LS_IDLE;
          if (!lsu_write)
            rdat_d = load_fmt(lsu.rdata, lane, lsu_size, lsu_signed);
        end
      end
    endcase
  end

  always_comb begin
    dc_val_d = dc_val_q;
    // Maintenance is software's job; a fresh fill wins over it
    if (dc_inv_all) dc_val_d = '0;
    else if (dc_inv_line) dc_val_d[inv_idx] = 1'b0;
    if (fill) dc_val_d[idx] = 1'b1;
  end

  always_ff @(posedge sys_clk) begin
    if (fill) begin
      dc_data[idx] <= lsu.rdata;
      dc_tag[idx]  <= tag;
    end else if (st_upd) begin
      dc_data[idx] <= merge(dc_data[idx], wlanes, be);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ls_q     <= cmm_pkg::CMM_LS_IDLE;
      done_q   <= 1'b0;
      rdat_q   <= 32'h0;
      dc_val_q <= '0;
    end else begin
      ls_q     <= ls_d;
      done_q   <= done_d;
      rdat_q   <= rdat_d;
      dc_val_q <= dc_val_d;
    end
  end

  assign lsu_done  = done_q;
  assign lsu_rdata = rdat_q;

  default clocking mcb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // Data port handshake
  one_xfer_a: assert property (
    !(dm_read && dm_write))
    else $error("read and write at once on data port");

  dm_hold_a: assert property (
    (dm_read || dm_write) && dm_waitrequest
    |=> (dm_read || dm_write) && $stable(dm_address))
    else $error("data transfer dropped during wait state");

  zero_wait_a: assert property (
    (dm_read || dm_write) && !dm_waitrequest
    |=> lsu_done && !dm_read && !dm_write)
    else $error("zero-wait access did not finish in one cycle");

  store_be_a: assert property (
    dm_write |-> dm_byteenable != 4'h0)
    else $error("store without byte lanes");

  load_read_a: assert property (
    accept && !lsu_write && bypass |=> dm_read && !dm_write)
    else $error("uncached load did not issue a read");

  store_write_a: assert property (
    accept && lsu_write |=> dm_write)
    else $error("store did not issue a write");

  uncached_bus_a: assert property (
    accept && lsu_uncached |=> (dm_read || dm_write))
    else $error("uncached access skipped the bus");

  byte_lane_a: assert property (
    dm_write && $past(lsu_size) == cmm_pkg::SZ_BYTE
    |-> dm_writedata[$past(lane)*8 +: 8] == $past(lsu_wdata[7:0]))
    else $error("byte store on wrong lane");

  no_starve_a: assert property (
    accept |=> dm_read || dm_write || lsu_done)
    else $error("data port did not start its access");

  word_addr_a: assert property (
    dm_read || dm_write |-> dm_address[1:0] == cmm_pkg::LANE_ZERO)
    else $error("data address not word aligned");

  load_lanes_a: assert property (
    dm_read |-> dm_byteenable == cmm_pkg::BE_WORD)
    else $error("load without all byte lanes");

  done_idle_a: assert property (
    lsu_done |-> !dm_read && !dm_write)
    else $error("data bus busy in done cycle");

  rdat_hold_a: assert property (
    $changed(lsu_rdata) |-> lsu_done)
    else $error("load result changed without done");

  // Cache behaviour
  hit_fast_a: assert property (
    hit_load |=> lsu_done && !dm_read)
    else $error("cache hit did not answer next cycle");

  inv_clear_a: assert property (
    dc_inv_all && !fill |=> dc_val_q == '0)
    else $error("line valid after invalidate all");

  hit_cov: cover property (hit_load);
  wait_cov: cover property (dm_write && dm_waitrequest ##1 dm_write);
  inv_cov: cover property (dc_inv_all ##2 accept);
  both_cov: cover property (im_read && (dm_read || dm_write));
endmodule : cmm_master_ports
`default_nettype wire

// ==== sim/cmm_fabric_model.sv ====
// Fabric model: pipelined fetch memory and waited data memory
`timescale 1ns/10ps
`default_nettype none
module cmm_fabric_model (
  input  wire logic        sys_clk,          // Clock
  input  wire logic        sys_rst,          // Sync reset
  input  wire logic        im_stall,         // Stall fetch every other cycle
  input  wire logic [3:0]  dm_wait_n,        // Data wait states
  input  wire logic        im_read,          // Fetch strobe
  input  wire logic [31:0] im_address,       // Fetch address
  output logic             im_waitrequest,   // Fetch stall
  output logic [31:0]      im_readdata,      // Fetch data
  output logic             im_readdatavalid, // Fetch data strobe
  input  wire logic        dm_read,          // Data read
  input  wire logic        dm_write,         // Data write
  input  wire logic [31:0] dm_address,       // Data address
  input  wire logic [3:0]  dm_byteenable,    // Byte lanes
  input  wire logic [31:0] dm_writedata,     // Store data
  output logic             dm_waitrequest,   // Data stall
  output logic [31:0]      dm_readdata       // Load data
);
  logic [31:0] mem [64];
  logic [31:0] fa_q [3];
  logic [2:0]  fv_q;
  logic [3:0]  cnt_q;
  logic        tog_q;
  initial for (int i = 0; i < 64; i++) mem[i] = 32'h0;
  assign im_waitrequest = im_stall & tog_q;
  // Data side has its own memory, so it never loses to fetch traffic
  assign dm_waitrequest = (dm_read | dm_write) && cnt_q != dm_wait_n;
  // Junk outside the accepted cycle, never the last value
  assign dm_readdata = (dm_read && !dm_waitrequest) ?
                       mem[dm_address[7:2]] : {32{tog_q}};
  always @(posedge sys_clk) begin
    tog_q <= sys_rst ? 1'b0 : ~tog_q;
    fv_q <= sys_rst ? 3'h0 : {fv_q[1:0], im_read & ~im_waitrequest};
    fa_q[0] <= im_address;
    fa_q[1] <= fa_q[0];
    fa_q[2] <= fa_q[1];
    im_readdatavalid <= ~sys_rst & fv_q[2];
    im_readdata <= fv_q[2] ? {~fa_q[2][15:0], fa_q[2][15:0]}
                           : {32{tog_q}};
    cnt_q <= (sys_rst || !dm_waitrequest) ? 4'h0 : cnt_q + 4'h1;
    if (dm_write && !dm_waitrequest)
      for (int b = 0; b < 4; b++)
        if (dm_byteenable[b])
          mem[dm_address[7:2]][b*8 +: 8] <= dm_writedata[b*8 +: 8];
  end
endmodule : cmm_fabric_model
`default_nettype wire

// ==== sim/test_cmm_master_ports.sv ====
// Self-checking bench of the processor memory master ports
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
  miscompares++; $display("unexpected at %0t: got %h expected %h", \
  $time, (g), (e)); end end
module test_cmm_master_ports;
  typedef struct packed {
    logic        wr;
    logic [1:0]  sz;
    logic        sgn;
    logic [31:0] addr;
    logic [31:0] wd;
    logic [31:0] exp;
  } cmm_row_s;
  localparam cmm_row_s ROWS [13] = '{
    '{1'b1, 2'h2, 1'b0, 32'h8000_0010, 32'h4433_2211, 32'h0000_000f},
    '{1'b0, 2'h2, 1'b0, 32'h8000_0010, 32'h0000_0000, 32'h4433_2211},
    '{1'b1, 2'h0, 1'b0, 32'h8000_0011, 32'h0000_00aa, 32'h0000_0002},
    '{1'b1, 2'h1, 1'b0, 32'h8000_0012, 32'h0000_beef, 32'h0000_000c},
    '{1'b0, 2'h2, 1'b0, 32'h8000_0010, 32'h0000_0000, 32'hbeef_aa11},
    '{1'b0, 2'h0, 1'b1, 32'h8000_0011, 32'h0000_0000, 32'hffff_ffaa},
    '{1'b0, 2'h0, 1'b0, 32'h8000_0013, 32'h0000_0000, 32'h0000_00be},
    '{1'b0, 2'h1, 1'b1, 32'h8000_0012, 32'h0000_0000, 32'hffff_beef},
    '{1'b0, 2'h1, 1'b0, 32'h8000_0010, 32'h0000_0000, 32'h0000_aa11},
    '{1'b1, 2'h0, 1'b0, 32'h8000_0013, 32'h0000_0077, 32'h0000_0008},
    '{1'b0, 2'h0, 1'b1, 32'h8000_0013, 32'h0000_0000, 32'h0000_0077},
    '{1'b1, 2'h0, 1'b0, 32'h8000_0010, 32'h0000_0001, 32'h0000_0001},
    '{1'b0, 2'h2, 1'b0, 32'h8000_0010, 32'h0000_0000, 32'h77ef_aa01}};
  logic        sys_clk, sys_rst, steer, lsu_req, lsu_write, lsu_uncached;
  logic        lsu_signed, dc_inv_line, dc_inv_all, im_stall, last_wr;
  logic [1:0]  lsu_size;
  logic [3:0]  dm_wait_n, last_be;
  logic [31:0] steer_pc, lsu_addr, lsu_wdata, dc_inv_addr, last_addr, exp_pc;
  logic        insn_valid, im_read, im_waitrequest, im_readdatavalid;
  logic        lsu_done, dm_read, dm_write, dm_waitrequest;
  logic [31:0] insn_word, insn_pc, im_address, im_readdata, lsu_rdata;
  logic [31:0] dm_address, dm_writedata, dm_readdata;
  logic [3:0]  dm_byteenable;
  int          miscompares = 0, total_checks = 0, xfers = 0, run = 0;
  int          last_run = 0, outst = 0, max_out = 0, n_insn = 0, x0, x1;

  cmm_master_ports u_cmm_master_ports (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .steer(steer), .steer_pc(steer_pc), .insn_valid(insn_valid),
    .insn_word(insn_word), .insn_pc(insn_pc), .im_read(im_read),
    .im_address(im_address), .im_waitrequest(im_waitrequest),
    .im_readdata(im_readdata), .im_readdatavalid(im_readdatavalid),
    .lsu_req(lsu_req), .lsu_write(lsu_write), .lsu_uncached(lsu_uncached),
    .lsu_size(lsu_size), .lsu_signed(lsu_signed), .lsu_addr(lsu_addr),
    .lsu_wdata(lsu_wdata), .lsu_done(lsu_done), .lsu_rdata(lsu_rdata),
    .dc_inv_line(dc_inv_line), .dc_inv_all(dc_inv_all),
    .dc_inv_addr(dc_inv_addr), .dm_read(dm_read), .dm_write(dm_write),
    .dm_address(dm_address), .dm_byteenable(dm_byteenable),
    .dm_writedata(dm_writedata), .dm_waitrequest(dm_waitrequest),
    .dm_readdata(dm_readdata));
  cmm_fabric_model u_cmm_fabric_model (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .im_stall(im_stall), .dm_wait_n(dm_wait_n), .im_read(im_read),
    .im_address(im_address), .im_waitrequest(im_waitrequest),
    .im_readdata(im_readdata), .im_readdatavalid(im_readdatavalid),
    .dm_read(dm_read), .dm_write(dm_write), .dm_address(dm_address),
    .dm_byteenable(dm_byteenable), .dm_writedata(dm_writedata),
    .dm_waitrequest(dm_waitrequest), .dm_readdata(dm_readdata));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic summarize();
    if (miscompares == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : tick

  // One load or store, held until the done pulse
  task automatic access(input logic wr, input logic unc,
                        input logic [1:0] sz, input logic sgn,
                        input logic [31:0] a, input logic [31:0] wd);
    int n;
    @(negedge sys_clk);
    lsu_req = 1'b1;
    lsu_write = wr;
    lsu_uncached = unc;
    lsu_size = sz;
    lsu_signed = sgn;
    lsu_addr = a;
    lsu_wdata = wd;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (lsu_done !== 1'b1 && n < 300);
    lsu_req = 1'b0;
    if (lsu_done !== 1'b1) begin
      miscompares++;
      summarize();
    end
  endtask : access

  // Sees pre-edge values of the registered outputs
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      exp_pc = cmm_pkg::RESET_PC;
      outst = 0;
      run = 0;
    end else begin
      if (dm_read | dm_write) run++;
      if ((dm_read | dm_write) && !dm_waitrequest) begin
        xfers++;
        last_be = dm_byteenable;
        last_addr = dm_address;
        last_wr = dm_write;
        last_run = run;
        run = 0;
      end
      if (im_read && !im_waitrequest) outst++;
      if (im_readdatavalid) outst--;
      if (outst > max_out) max_out = outst;
      if (insn_valid) begin
        `CHK(insn_pc, exp_pc)
        `CHK(insn_word, {~exp_pc[15:0], exp_pc[15:0]})
        exp_pc += 32'h4;
        n_insn++;
      end
      if (steer) exp_pc = steer_pc;
    end
  end

  initial begin
    {sys_rst, steer, lsu_req, lsu_write, lsu_uncached} = 5'h10;
    {lsu_signed, dc_inv_line, dc_inv_all, im_stall} = 4'h0;
    {lsu_size, dm_wait_n} = 6'h0;
    {steer_pc, lsu_addr, lsu_wdata, dc_inv_addr} = 128'h0;
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK({im_read, dm_read, dm_write, lsu_done, insn_valid}, 5'h0)
    sys_rst = 1'b0;
    x1 = n_insn;
    foreach (ROWS[i]) begin
      access(ROWS[i].wr, 1'b1, ROWS[i].sz, ROWS[i].sgn, ROWS[i].addr,
             ROWS[i].wd);
      `CHK(last_wr, ROWS[i].wr)
      `CHK(last_addr, ROWS[i].addr & 32'hffff_fffc)
      `CHK(last_run, 1)
      if (ROWS[i].wr) `CHK(last_be, ROWS[i].exp[3:0])
      else `CHK(lsu_rdata, ROWS[i].exp)
    end
    // Wait states while fetch is stalled too
    dm_wait_n = 4'h3;
    im_stall = 1'b1;
    access(1'b1, 1'b1, 2'h2, 1'b0, 32'h8000_0020, 32'h1234_5678);
    `CHK(last_run, 4)
    access(1'b0, 1'b1, 2'h2, 1'b0, 32'h8000_0020, 32'h0);
    `CHK(lsu_rdata, 32'h1234_5678)
    `CHK(n_insn > x1, 1'b1)
    dm_wait_n = 4'h0;
    im_stall = 1'b0;
    x0 = xfers;
    access(1'b0, 1'b1, 2'h2, 1'b0, 32'h8000_0020, 32'h0);
    access(1'b0, 1'b1, 2'h2, 1'b0, 32'h8000_0020, 32'h0);
    `CHK(xfers - x0, 2)
    x0 = xfers;
    access(1'b0, 1'b0, 2'h2, 1'b0, 32'h0000_0020, 32'h0);
    access(1'b0, 1'b0, 2'h2, 1'b0, 32'h0000_0020, 32'h0);
    `CHK(lsu_rdata, 32'h1234_5678)
    `CHK(xfers - x0, 1)
    // Bypass store leaves the cached copy stale
    access(1'b1, 1'b1, 2'h2, 1'b0, 32'h8000_0020, 32'hcafe_f00d);
    access(1'b0, 1'b0, 2'h2, 1'b0, 32'h0000_0020, 32'h0);
    `CHK(lsu_rdata, 32'h1234_5678)
    @(negedge sys_clk);
    dc_inv_addr = 32'h0000_0020;
    dc_inv_line = 1'b1;
    @(negedge sys_clk);
    dc_inv_line = 1'b0;
    x0 = xfers;
    access(1'b0, 1'b0, 2'h2, 1'b0, 32'h0000_0020, 32'h0);
    `CHK(lsu_rdata, 32'hcafe_f00d)
    @(negedge sys_clk);
    dc_inv_all = 1'b1;
    @(negedge sys_clk);
    dc_inv_all = 1'b0;
    access(1'b0, 1'b0, 2'h2, 1'b0, 32'h0000_0020, 32'h0);
    `CHK(xfers - x0, 2)
    // Cached byte store writes through and updates the hit line
    x0 = xfers;
    access(1'b1, 1'b0, 2'h0, 1'b0, 32'h0000_0021, 32'h0000_005a);
    access(1'b0, 1'b0, 2'h2, 1'b0, 32'h0000_0020, 32'h0);
    `CHK(lsu_rdata, 32'hcafe_5a0d)
    `CHK(xfers - x0, 1)
    // Redirect with returns still in flight
    im_stall = 1'b1;
    @(negedge sys_clk);
    steer = 1'b1;
    steer_pc = 32'h0000_0100;
    @(negedge sys_clk);
    steer = 1'b0;
    im_stall = 1'b0;
    x0 = n_insn;
    tick(30);
    `CHK(n_insn > x0, 1'b1)
    `CHK(max_out > 1, 1'b1)
    `CHK(max_out <= cmm_pkg::MAX_OUT, 1'b1)
    // Second reset in mid-run
    sys_rst = 1'b1;
    tick(2);
    `CHK({im_read, dm_read, dm_write, lsu_done, insn_valid}, 5'h0)
    sys_rst = 1'b0;
    access(1'b0, 1'b1, 2'h2, 1'b0, 32'h8000_0020, 32'h0);
    `CHK(lsu_rdata, 32'hcafe_5a0d)
    tick(20);
    summarize();
  end
endmodule : test_cmm_master_ports
`default_nettype wire
